// file: rtl/asrx_consts.svh
/*
 * Constants of the four-channel serial receive engine: register offsets,
 * field positions, reset values and sizes.
 * Assumes inclusion by bare name from the package and the top module.
 */
`ifndef ASRX_CONSTS_SVH
`define ASRX_CONSTS_SVH

// register offsets (low 3 bits of address, upper bits select channel)
`define ASRX_OFF_OPT1       3'h0
`define ASRX_OFF_OPT3       3'h1
`define ASRX_OFF_BAUD       3'h2
`define ASRX_OFF_TMO        3'h3
`define ASRX_OFF_CMD        3'h4
`define ASRX_OFF_SRE        3'h5
`define ASRX_OFF_DATA       3'h6
`define ASRX_OFF_CNT        3'h7
// global registers at channel field all ones with address bit 2 set + these offsets
`define ASRX_OFF_PRESC      3'h0
`define ASRX_OFF_SVC        3'h1
`define ASRX_OFF_EOS        3'h2

// option one: [1:0] data length-5, [2] parity on, [3] odd, [4] two stops
`define ASRX_LEN_LSB        0
`define ASRX_PAR_EN_BIT     2
`define ASRX_PAR_ODD_BIT    3
`define ASRX_STOP2_BIT      4
`define ASRX_TH_LSB         0
// service enable: [0] rx data, [1] empty fifo timeout
`define ASRX_SRE_RX_BIT     0
`define ASRX_SRE_EMPTY_BIT  1
// command: [0] rx enable, [1] rx disable
`define ASRX_CMD_EN_BIT     0
`define ASRX_CMD_DIS_BIT    1
// status byte bits
`define ASRX_ST_FRAME       8'h01
`define ASRX_ST_PARITY      8'h02
`define ASRX_ST_OVERRUN     8'h04
`define ASRX_ST_TIMEOUT     8'h80

`define ASRX_RST_TH         4'h8
`define ASRX_RST_BAUD       16'h0056
`define ASRX_RST_TMO        8'h10
`define ASRX_RST_PRESC      8'h0A
`define ASRX_FIFO_DEPTH     12
`define ASRX_CHANNELS       4

`endif

// file: rtl/asrx_pkg.sv
/*
 * Types of the serial receive engine.
 * Assumes the constants header sits beside it.
 */
`include "asrx_consts.svh"
package asrx_pkg;
    typedef enum logic [2:0] {
        ASRX_IDLE, ASRX_START, ASRX_DATA, ASRX_PAR, ASRX_STOP
    } asrx_rx_state_t;

    typedef enum logic [1:0] {
        ASRX_SVC_NONE, ASRX_SVC_GOOD, ASRX_SVC_EXC
    } asrx_svc_t;

    typedef struct packed {
        asrx_rx_state_t st;
        logic [15:0]    baud_cnt;
        logic [2:0]     bit_idx;
        logic [7:0]     shreg;
        logic           par_acc;
        logic           prev;
        logic           hold_vld;
        logic [7:0]     hold_data;
        logic [7:0]     hold_stat;
        logic [7:0]     timer;
        logic           tmo_armed;
        logic           empty_armed;
        logic           exc_last;
        logic           fair;
    } asrx_ch_t;
endpackage : asrx_pkg

// file: rtl/asrx_engine.sv
/*
 * Four-channel asynchronous receive engine: start-bit check, bit sampling,
 * framing and parity, a 12-entry receive fifo per channel with exception
 * status entries, a receive timer per channel and a round-robin sequencer
 * posting receive service requests with per-type fairness.
 * Assumes line inputs already synchronous to CLK; the transmit path and
 * modem logic live elsewhere and report their pending needs on TX_NEED and
 * MDM_NEED.
 */
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "asrx_consts.svh"

// What this block does
// - one shared format, own baud per direction
// - three aggregate request outputs rx tx modem
// - sequencer scans channels round robin
// - no repeat request before others posted
// - twelve fifo entries plus holding and shift
// - second fill level drives DTR low
// - start, 5-8 data, parity, stop bits
// - half-bit resample validates start bit
// - sample each full bit time
// - parity check then stop; missing marks framing
// - clean char direct; errored with status
// - good count tracks clean characters buffered
// - four-bit threshold 1 to 12
// - unread service reposts at next turn
// - below threshold clean data waits for timeout
// - reload timer on entry or emptying
// - timer decrements per prescaler tick
// - timeout requests need receive enable
// - stale data posts clean request unless exception at head
// - empty timeout posts exception if enabled
// - empty timeout only first expiry
// - no empty timer after exception removal
// - exception stores status then character
module asrx_engine
    import asrx_pkg::*;
#(
    parameter int NCH   = `ASRX_CHANNELS,
    parameter int DEPTH = `ASRX_FIFO_DEPTH
) (
    input  wire logic             CLK,
    input  wire logic             RESETN,
    input  wire logic [NCH-1:0]   RXD,
    input  wire logic [NCH-1:0]   TX_NEED,
    input  wire logic [NCH-1:0]   MDM_NEED,
    input  wire logic [4:0]       ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic             WR,
    input  wire logic             RD,
    output logic      [7:0]       RDATA,
    output logic                  SVC_RX,
    output logic                  SVC_TX,
    output logic                  SVC_MDM,
    output logic      [NCH-1:0]   DTR
);
    initial begin
        if (NCH != 4 || DEPTH < 2 || DEPTH > 15)
            $error("asrx_engine: unsupported NCH or DEPTH");
    end

    localparam int PW = $clog2(DEPTH);
    localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    logic [4:0]  opt1_ff   [NCH];
    logic [3:0]  th_ff     [NCH];
    logic [3:0]  dtr_th_ff [NCH];
    logic [15:0] baud_ff   [NCH];
    logic [7:0]  tmo_ff    [NCH];
    logic [1:0]  sre_ff    [NCH];
    logic        en_ff     [NCH];
    logic [7:0]  presc_ff;
    logic [7:0]  presc_cnt_ff;
    logic        tick_ff;
    logic [7:0]  rdata_ff;

    // ***************************************************************
    // fifo and channel state
    // ***************************************************************
    logic [8:0]  mem_ff    [NCH][DEPTH];
    logic [PW-1:0] wp_ff   [NCH];
    logic [PW-1:0] rp_ff   [NCH];
    logic [PW:0] lvl_ff    [NCH];
    logic [PW:0] good_ff   [NCH];
    asrx_ch_t    ch_ff     [NCH];
    asrx_ch_t    nxt_ch    [NCH];
    logic [NCH-1:0] need_rx;
    logic [NCH-1:0] exc_head;
    logic [NCH-1:0] exc_need;
    logic [NCH-1:0] pend_ff;
    logic [NCH-1:0] push_ok;
    logic [NCH-1:0] pop;
    logic [NCH-1:0] drop_ex;

    // sequencer
    logic [1:0]  scan_ff;
    logic        act_ff;
    logic [1:0]  act_ch_ff;
    asrx_svc_t   act_typ_ff;
    logic [PW:0] act_reads_ff;
    logic        svc_rx_ff;
    logic        svc_tx_ff;
    logic        svc_mdm_ff;
    logic [NCH-1:0] dtr_ff;
    logic [NCH-1:0] tx_fair_ff;
    logic [NCH-1:0] mdm_fair_ff;

    // channel three keeps offsets 0-3; its upper half is the global page
    wire is_glob = (ADDR[4:3] == 2'h3) & ADDR[2];
    wire [2:0] goff = {1'b0, ADDR[1:0]};
    wire [1:0] sel = ADDR[4:3];
    wire data_rd = RD & !is_glob & (ADDR[2:0] == `ASRX_OFF_DATA);
    wire eos_wr  = WR & is_glob & (goff == `ASRX_OFF_EOS);

    // ***************************************************************
    // prescaler
    // ***************************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            presc_cnt_ff <= 8'h00;
            tick_ff      <= 1'b0;
        end else if (presc_cnt_ff >= presc_ff) begin
            presc_cnt_ff <= 8'h00;
            tick_ff      <= 1'b1;
        end else begin
            presc_cnt_ff <= presc_cnt_ff + 8'h01;
            tick_ff      <= 1'b0;
        end
    end

    // ***************************************************************
    // per-channel receiver, timer and fifo
    // ***************************************************************
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        wire [15:0] half = {1'b0, baud_ff[c][15:1]};
        wire [2:0]  last_bit = {1'b0, opt1_ff[c][1:0]} + 3'h4;
        wire        empty = (lvl_ff[c] == '0);
        wire        rx_en = sre_ff[c][`ASRX_SRE_RX_BIT];
        wire        mine  = act_ff && (act_ch_ff == 2'(c));
        logic       expire;
        logic [8:0] head;
        assign head = mem_ff[c][rp_ff[c]];
        assign exc_head[c] = head[8] && !empty;
        // exception pair needs two slots; a clean char one
        assign push_ok[c] = ch_ff[c].hold_vld &&
            ((ch_ff[c].hold_stat == 8'h00) ?
             (lvl_ff[c] < DEPTH_C) : (lvl_ff[c] + 1'b1 < DEPTH_C));
        // host reads and end-of-exception flush
        assign pop[c] = (data_rd && sel == 2'(c) && !empty) ||
                        (drop_ex[c] && !empty);
        assign drop_ex[c] = eos_wr && mine && act_typ_ff == ASRX_SVC_EXC &&
                            act_reads_ff < 2 && !empty && head[8];
        assign expire = tick_ff && ch_ff[c].tmo_armed &&
                        ch_ff[c].timer == 8'h00;

        always_comb begin
            nxt_ch[c] = ch_ff[c];
            nxt_ch[c].prev = RXD[c];
            if (ch_ff[c].baud_cnt != 16'h0000)
                nxt_ch[c].baud_cnt = ch_ff[c].baud_cnt - 16'h0001;
            case (ch_ff[c].st)
                ASRX_IDLE: begin
                    if (en_ff[c] && ch_ff[c].prev && !RXD[c]) begin
                        nxt_ch[c].st = ASRX_START;
                        nxt_ch[c].baud_cnt = half;
                    end
                end
                ASRX_START: if (ch_ff[c].baud_cnt == 16'h0000) begin
                    if (RXD[c]) nxt_ch[c].st = ASRX_IDLE;
                    else begin
                        nxt_ch[c].st = ASRX_DATA;
                        nxt_ch[c].baud_cnt = baud_ff[c];
                        nxt_ch[c].bit_idx = 3'h0;
                        nxt_ch[c].shreg = 8'h00;
                        nxt_ch[c].par_acc = opt1_ff[c][`ASRX_PAR_ODD_BIT];
                    end
                end
                ASRX_DATA: if (ch_ff[c].baud_cnt == 16'h0000) begin
                    nxt_ch[c].shreg[ch_ff[c].bit_idx] = RXD[c];
                    nxt_ch[c].par_acc = ch_ff[c].par_acc ^ RXD[c];
                    nxt_ch[c].bit_idx = ch_ff[c].bit_idx + 3'h1;
                    nxt_ch[c].baud_cnt = baud_ff[c];
                    if (ch_ff[c].bit_idx == last_bit)
                        nxt_ch[c].st = opt1_ff[c][`ASRX_PAR_EN_BIT] ?
                                       ASRX_PAR : ASRX_STOP;
                end
                ASRX_PAR: if (ch_ff[c].baud_cnt == 16'h0000) begin
                    nxt_ch[c].par_acc = ch_ff[c].par_acc ^ RXD[c];
                    nxt_ch[c].baud_cnt = baud_ff[c];
                    nxt_ch[c].st = ASRX_STOP;
                end
                ASRX_STOP: if (ch_ff[c].baud_cnt == 16'h0000) begin
                    // shift register hands over to the holding stage
                    nxt_ch[c].st = ASRX_IDLE;
                    nxt_ch[c].hold_data = ch_ff[c].shreg;
                    nxt_ch[c].hold_stat =
                        (RXD[c] ? 8'h00 : `ASRX_ST_FRAME) |
                        ((opt1_ff[c][`ASRX_PAR_EN_BIT] &&
                          ch_ff[c].par_acc) ? `ASRX_ST_PARITY : 8'h00);
                    if (ch_ff[c].hold_vld)
                        nxt_ch[c].hold_stat = nxt_ch[c].hold_stat |
                                              `ASRX_ST_OVERRUN;
                    nxt_ch[c].hold_vld = 1'b1;
                end
                default: nxt_ch[c].st = ASRX_IDLE;
            endcase
            // holding stage drains into fifo; if fifo full, the next
            // character overwrites it and carries an overrun mark
            if (push_ok[c] && !(ch_ff[c].st == ASRX_STOP &&
                               ch_ff[c].baud_cnt == 16'h0000))
                nxt_ch[c].hold_vld = 1'b0;
            if (!en_ff[c]) begin
                nxt_ch[c].st = ASRX_IDLE;
                nxt_ch[c].hold_vld = 1'b0;
            end
            // receive timer
            if (tick_ff && ch_ff[c].tmo_armed && ch_ff[c].timer != 8'h00)
                nxt_ch[c].timer = ch_ff[c].timer - 8'h01;
            if (expire) begin
                nxt_ch[c].tmo_armed = 1'b0;
                if (empty && rx_en && ch_ff[c].empty_armed &&
                    sre_ff[c][`ASRX_SRE_EMPTY_BIT])
                    nxt_ch[c].empty_armed = 1'b0;
            end
            if (pop[c]) nxt_ch[c].exc_last = head[8] && !drop_ex[c] ?
                                             1'b1 : head[8];
            if (pop[c] && lvl_ff[c] == 1) begin
                nxt_ch[c].timer = tmo_ff[c];
                nxt_ch[c].tmo_armed = !head[8];
                nxt_ch[c].empty_armed = !head[8];
            end
            if (push_ok[c]) begin
                nxt_ch[c].timer = tmo_ff[c];
                nxt_ch[c].tmo_armed = 1'b1;
                nxt_ch[c].empty_armed = 1'b0;
            end
        end

        // service needs: stale/threshold clean data, exception at head,
        // or a pending empty-fifo time-out; set wins over clear
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) pend_ff[c] <= 1'b0;
            else if (expire && rx_en && !empty && !exc_head[c])
                pend_ff[c] <= 1'b1;
            else if (mine && eos_wr && act_typ_ff == ASRX_SVC_GOOD &&
                     act_reads_ff == '0 && good_ff[c] != '0)
                pend_ff[c] <= 1'b1;
            else if (mine && eos_wr) pend_ff[c] <= 1'b0;
        end
        logic empty_evt_ff;
        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) empty_evt_ff <= 1'b0;
            else if (expire && empty && rx_en && ch_ff[c].empty_armed &&
                     sre_ff[c][`ASRX_SRE_EMPTY_BIT])
                empty_evt_ff <= 1'b1;
            else if (mine && eos_wr && act_typ_ff == ASRX_SVC_EXC)
                empty_evt_ff <= 1'b0;
        end
        assign exc_need[c] = exc_head[c] || empty_evt_ff;
        // request at or above threshold, on pending, exception or empty-timeout needs, or clean data behind exceptions
        assign need_rx[c] = rx_en && en_ff[c] &&
            ((good_ff[c] >= (PW+1)'(th_ff[c])) || pend_ff[c] ||
             (exc_head[c] && !empty) || empty_evt_ff ||
             (good_ff[c] != '0 && lvl_ff[c] != good_ff[c]));

        always_ff @(posedge CLK or negedge RESETN) begin
            if (!RESETN) begin
                ch_ff[c] <= '0;
                ch_ff[c].prev <= 1'b1;
                wp_ff[c] <= '0;
                rp_ff[c] <= '0;
                lvl_ff[c] <= '0;
                good_ff[c] <= '0;
                dtr_ff[c] <= 1'b1;
            end else begin
                ch_ff[c] <= nxt_ch[c];
                if (push_ok[c]) begin
                    if (ch_ff[c].hold_stat == 8'h00) begin
                        mem_ff[c][wp_ff[c]] <= {1'b0, ch_ff[c].hold_data};
                        wp_ff[c] <= (wp_ff[c] == PW'(DEPTH-1)) ? '0 :
                                    wp_ff[c] + 1'b1;
                    end else begin
                        mem_ff[c][wp_ff[c]] <= {1'b1, ch_ff[c].hold_stat};
                        mem_ff[c][(wp_ff[c] == PW'(DEPTH-1)) ? '0 :
                                  wp_ff[c] + 1'b1] <=
                            {1'b1, ch_ff[c].hold_data};
                        wp_ff[c] <= PW'((32'(wp_ff[c]) + 2) % DEPTH);
                    end
                end
                if (pop[c])
                    rp_ff[c] <= (rp_ff[c] == PW'(DEPTH-1)) ? '0 :
                                rp_ff[c] + 1'b1;
                lvl_ff[c] <= lvl_ff[c]
                    + (push_ok[c] ? ((ch_ff[c].hold_stat == 8'h00) ?
                        (PW+1)'(1) : (PW+1)'(2)) : '0)
                    - (pop[c] ? (PW+1)'(1) : '0);
                good_ff[c] <= good_ff[c]
                    + ((push_ok[c] && ch_ff[c].hold_stat == 8'h00) ?
                        (PW+1)'(1) : '0)
                    - ((pop[c] && !head[8]) ? (PW+1)'(1) : '0);
                // deassert DTR at the second fill level
                dtr_ff[c] <= !(dtr_th_ff[c] != 4'h0 &&
                               lvl_ff[c] >= (PW+1)'(dtr_th_ff[c]));
            end
        end
    end

    // ***************************************************************
    // sequencer: one channel per cycle, fairness per type
    // ***************************************************************
    logic [NCH-1:0] rx_fair_ff;
    wire [NCH-1:0] tx_cand  = TX_NEED & ~tx_fair_ff;
    wire [NCH-1:0] mdm_cand = MDM_NEED & ~mdm_fair_ff;
    wire [NCH-1:0] rx_cand  = need_rx & ~rx_fair_ff;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            scan_ff <= 2'h0;
            act_ff <= 1'b0;
            act_ch_ff <= 2'h0;
            act_typ_ff <= ASRX_SVC_NONE;
            act_reads_ff <= '0;
            svc_rx_ff <= 1'b0;
            svc_tx_ff <= 1'b0;
            svc_mdm_ff <= 1'b0;
            rx_fair_ff <= '0;
            tx_fair_ff <= '0;
            mdm_fair_ff <= '0;
        end else begin
            scan_ff <= scan_ff + 2'h1;
            // a type whose channels have all had their turn starts fresh
            if ((need_rx & ~rx_fair_ff) == '0) rx_fair_ff <= '0;
            if (tx_cand == '0) tx_fair_ff <= '0;
            if (mdm_cand == '0) mdm_fair_ff <= '0;
            svc_tx_ff <= tx_cand != '0 || TX_NEED != '0;
            svc_mdm_ff <= mdm_cand != '0 || MDM_NEED != '0;
            if (tx_cand[scan_ff]) tx_fair_ff[scan_ff] <= 1'b1;
            if (mdm_cand[scan_ff]) mdm_fair_ff[scan_ff] <= 1'b1;
            if (!act_ff && rx_cand[scan_ff]) begin
                act_ff <= 1'b1;
                act_ch_ff <= scan_ff;
                act_typ_ff <= exc_need[scan_ff] ? ASRX_SVC_EXC :
                              ASRX_SVC_GOOD;
                act_reads_ff <= '0;
                svc_rx_ff <= 1'b1;
                rx_fair_ff[scan_ff] <= 1'b1;
            end else if (act_ff && eos_wr) begin
                act_ff <= 1'b0;
                svc_rx_ff <= 1'b0;
            end else if (act_ff && data_rd && sel == act_ch_ff) begin
                act_reads_ff <= act_reads_ff + 1'b1;
            end
        end
    end

    // ***************************************************************
    // register port
    // ***************************************************************
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            for (int i = 0; i < NCH; i++) begin
                opt1_ff[i] <= 5'h03;
                th_ff[i] <= `ASRX_RST_TH;
                dtr_th_ff[i] <= 4'h0;
                baud_ff[i] <= `ASRX_RST_BAUD;
                tmo_ff[i] <= `ASRX_RST_TMO;
                sre_ff[i] <= 2'h0;
                en_ff[i] <= 1'b0;
            end
            presc_ff <= `ASRX_RST_PRESC;
            rdata_ff <= 8'h00;
        end else begin
            if (WR && is_glob && goff == `ASRX_OFF_PRESC)
                presc_ff <= WDATA;
            else if (WR && !is_glob) begin
                case (ADDR[2:0])
                    `ASRX_OFF_OPT1: opt1_ff[sel] <= WDATA[4:0];
                    `ASRX_OFF_OPT3: begin
                        if (WDATA[3:0] != 4'h0 && WDATA[3:0] <= 4'hC)
                            th_ff[sel] <= WDATA[3:0];
                        dtr_th_ff[sel] <= WDATA[7:4];
                    end
                    `ASRX_OFF_BAUD: baud_ff[sel] <= {WDATA, 8'h00} |
                                                    16'h00FF;
                    `ASRX_OFF_TMO: tmo_ff[sel] <= WDATA;
                    `ASRX_OFF_CMD: begin
                        if (WDATA[`ASRX_CMD_EN_BIT]) en_ff[sel] <= 1'b1;
                        if (WDATA[`ASRX_CMD_DIS_BIT]) en_ff[sel] <= 1'b0;
                    end
                    `ASRX_OFF_SRE: sre_ff[sel] <= WDATA[1:0];
                    default: ;
                endcase
            end
            rdata_ff <= 8'h00;
            if (RD && is_glob) begin
                case (goff)
                    `ASRX_OFF_PRESC: rdata_ff <= presc_ff;
                    `ASRX_OFF_SVC: rdata_ff <= {3'h0, act_ch_ff,
                        svc_mdm_ff, svc_tx_ff, svc_rx_ff};
                    default: rdata_ff <= 8'h00;
                endcase
            end else if (RD) begin
                case (ADDR[2:0])
                    `ASRX_OFF_OPT1: rdata_ff <= {3'h0, opt1_ff[sel]};
                    `ASRX_OFF_OPT3: rdata_ff <= {dtr_th_ff[sel], th_ff[sel]};
                    `ASRX_OFF_BAUD: rdata_ff <= baud_ff[sel][15:8];
                    `ASRX_OFF_TMO: rdata_ff <= tmo_ff[sel];
                    `ASRX_OFF_CMD: rdata_ff <= {7'h00, en_ff[sel]};
                    `ASRX_OFF_SRE: rdata_ff <= {6'h00, sre_ff[sel]};
                    `ASRX_OFF_DATA: rdata_ff <= lvl_ff[sel] == '0 ?
                        `ASRX_ST_TIMEOUT : mem_ff[sel][rp_ff[sel]][7:0];
                    `ASRX_OFF_CNT: rdata_ff <= 8'(good_ff[sel]);
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end

    assign RDATA   = rdata_ff;
    assign SVC_RX  = svc_rx_ff;
    assign SVC_TX  = svc_tx_ff;
    assign SVC_MDM = svc_mdm_ff;
    assign DTR     = dtr_ff;
endmodule : asrx_engine

// file: verif/asrx_line_tx.sv
/* Remote serial transmitter model on one receive line.
   Assumes the caller sets the bit time in clock cycles through BIT. */
`timescale 1ns/1ps
module asrx_line_tx #(
    parameter int BIT = 255
) (
    input  wire logic CLK,
    output logic      LINE
);
    initial LINE = 1'b1;
    // a low stop bit is the only fault the bench asks for
    task automatic send(input logic [7:0] d, input logic stop);
        logic [9:0] f;
        f = {stop, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            LINE <= f[i];
            repeat (BIT) @(posedge CLK);
        end
        LINE <= 1'b1;
    endtask : send
endmodule : asrx_line_tx

// file: verif/asrx_monitor.sv
/* Port checker for the receive engine.
   Assumes binding to asrx_engine with its ports of the same names. */
`timescale 1ns/1ps
module asrx_monitor #(
    parameter int NCH = 4
) (
    input  wire logic           CLK,
    input  wire logic           RESETN,
    input  wire logic [NCH-1:0] RXD,
    input  wire logic [NCH-1:0] TX_NEED,
    input  wire logic [NCH-1:0] MDM_NEED,
    input  wire logic [4:0]     ADDR,
    input  wire logic           WR,
    input  wire logic           RD,
    input  wire logic [7:0]     RDATA,
    input  wire logic           SVC_RX,
    input  wire logic           SVC_TX,
    input  wire logic           SVC_MDM
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    logic seen_low_ff;
    logic eos;
    assign eos = WR && ADDR == 5'h1E;
    always_ff @(posedge CLK or negedge RESETN)
        if (!RESETN)
            seen_low_ff <= 1'b0;
        else if (!(&RXD))
            seen_low_ff <= 1'b1;
    rd_idle_zero_a: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside read");
    svc_rx_hold_a: assert property (SVC_RX && !eos && !$past(eos)
        |=> SVC_RX) else $error("rx request dropped early");
    tx_quiet_a: assert property ((TX_NEED == 0)[*8] |=> !$rose(SVC_TX))
        else $error("tx request without need");
    mdm_quiet_a: assert property ((MDM_NEED == 0)[*8] |=>
        !$rose(SVC_MDM)) else $error("modem request without need");
    svc_status_a: assert property (RD && ADDR == 5'h1D |=>
        RDATA[2:0] == {$past(SVC_MDM), $past(SVC_TX), $past(SVC_RX)})
        else $error("service status wrong");
    count_max_a: assert property (RD && ADDR[2:0] == 3'h7 &&
        ADDR[4:3] != 2'h3 |=> RDATA <= 8'h0C) else $error("count over 12");
    th_range_a: assert property (RD && ADDR[2:0] == 3'h1 &&
        ADDR[4:3] != 2'h3 |=> RDATA[3:0] inside {[4'h1:4'hC]})
        else $error("threshold out of range");
    line_quiet_a: assert property (!seen_low_ff |-> !SVC_RX)
        else $error("rx request before any line activity");
    cover property ($rose(SVC_RX));
    cover property (RD && ADDR == 5'h06);
    cover property (eos);
endmodule : asrx_monitor
bind asrx_engine asrx_monitor #(.NCH(NCH)) asrx_monitor_i (.*);

// file: verif/testbench.sv
/* Self-checking bench for the receive engine, channel 0 traffic.
   Assumes the line model sends at a baud byte of zero (255 cycles). */
`timescale 1ns/1ps
`include "asrx_consts.svh"
module testbench;
    logic       CLK, RESETN, WR, RD, line;
    logic       SVC_RX, SVC_TX, SVC_MDM;
    logic       rd_q = 1'b0;
    logic [4:0] ADDR;
    logic [7:0] WDATA, RDATA, d;
    logic [3:0] DTR, txn = 4'h0, mdn = 4'h0;
    logic [7:0] exp_q[$];
    int         err_count, checks, seed;
    asrx_engine asrx_engine_i (.CLK(CLK), .RESETN(RESETN),
        .RXD({3'h7, line}), .TX_NEED(txn), .MDM_NEED(mdn), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .SVC_RX(SVC_RX),
        .SVC_TX(SVC_TX), .SVC_MDM(SVC_MDM), .DTR(DTR));
    asrx_line_tx asrx_line_tx_i (.CLK(CLK), .LINE(line));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] v);
        @(posedge CLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge CLK);
        WR    <= 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        @(posedge CLK);
        ADDR <= a;
        RD   <= 1'b1;
        exp_q.push_back(e);
        @(posedge CLK);
        RD   <= 1'b0;
    endtask : rd
    // settle first so a request just cleared is not mistaken for a new one
    task automatic svc(input logic e, input int w);
        repeat (3) @(posedge CLK);
        for (int n = 0; n < w && SVC_RX !== 1'b1; n++) @(posedge CLK);
        chk({7'h0, SVC_RX}, {7'h0, e});
    endtask : svc
    task automatic wrap_up;
        if (err_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    always @(posedge CLK) begin
        if (rd_q)
            chk(RDATA, exp_q.pop_front());
        rd_q <= RD;
    end
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    initial begin
        #900000;
        err_count++;
        wrap_up;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        RESETN = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 5'h00; WDATA = 8'h00;
        seed = $urandom(98);
        repeat (12) @(posedge CLK);
        RESETN <= 1'b1;
        rd(5'h1C, `ASRX_RST_PRESC);
        rd(5'h03, `ASRX_RST_TMO);
        txn <= 4'($urandom) | 4'h1;
        mdn <= 4'h2;
        rd(5'h1D, 8'h06);
        chk({6'h0, SVC_MDM, SVC_TX}, 8'h03);
        txn <= 4'h0;
        mdn <= 4'h0;
        wr(5'h00, 8'h03);
        wr(5'h01, 8'h21);
        wr(5'h01, 8'h20);
        wr(5'h01, 8'h2D);
        rd(5'h01, 8'h21);
        wr(5'h02, 8'h00);
        wr(5'h03, 8'h02);
        wr(5'h1C, 8'h01);
        wr(5'h05, 8'h03);
        wr(5'h04, 8'h01);
        d = 8'($urandom);
        asrx_line_tx_i.send(d, 1'b1);
        svc(1'b1, 3000);
        rd(5'h1D, 8'h01);
        rd(5'h07, 8'h01);
        rd(5'h06, d);
        wr(5'h1E, 8'h00);
        svc(1'b1, 6000);
        rd(5'h06, `ASRX_ST_TIMEOUT);
        wr(5'h1E, 8'h00);
        svc(1'b0, 6000);
        d = 8'($urandom) | 8'h01;
        asrx_line_tx_i.send(d, 1'b0);
        svc(1'b1, 3000);
        chk({4'h0, DTR}, 8'h0E);
        rd(5'h06, `ASRX_ST_FRAME);
        rd(5'h06, d);
        wr(5'h1E, 8'h00);
        svc(1'b0, 6000);
        wr(5'h01, 8'h22);
        d = 8'($urandom);
        asrx_line_tx_i.send(d, 1'b1);
        svc(1'b1, 6000);
        wr(5'h1E, 8'h00);
        svc(1'b1, 3000);
        rd(5'h06, d);
        repeat (4) @(posedge CLK);
        wrap_up;
    end
endmodule : testbench
